//--- fixture_pkg.sv
`default_nettype none
package fixture_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] CMD_OFFSET    = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] RESP_OFFSET   = 8'h08;
  localparam logic [7:0] ERRIN_OFFSET  = 8'h0C;
  localparam logic [7:0] SRQACK_OFFSET = 8'h10;
  localparam logic [7:0] SCOPE_OFFSET  = 8'h14;

  // ==========================================================
  // Command word fields
  localparam int CMD_ADDR_LSB  = 0;
  localparam int CMD_OP_LSB    = 8;
  localparam int CMD_ARG_LSB   = 16;
  localparam int CMD_EOI_BIT   = 24;
  localparam int CMD_QUERY_BIT = 25;

  typedef enum logic [3:0] {
    OP_IDENT    = 4'h0,
    OP_NAME     = 4'h1,
    OP_ERROR    = 4'h2,
    OP_RESTORE  = 4'h3,
    OP_RQS      = 4'h4,
    OP_LOCK     = 4'h5,
    OP_UNLOCK   = 4'h6,
    OP_FACTORY  = 4'h7,
    OP_CH2TOG   = 4'h8,
    OP_CH1SCALE = 4'h9,
    OP_TIMEBASE = 4'hA,
    OP_BWTOG    = 4'hB
  } opcode_type;

  localparam logic [7:0] ARG_OFF   = 8'h00;
  localparam logic [7:0] ARG_ON    = 8'h01;
  localparam logic [7:0] ARG_QUERY = 8'h02;

  // ==========================================================
  // Scale codes, 1-2-5 steps from 2 mV and from 1 us
  localparam logic [7:0] VDIV_10MV  = 8'h02;
  localparam logic [7:0] VDIV_100MV = 8'h05;
  localparam logic [7:0] VDIV_MAX   = 8'h0C;
  localparam logic [7:0] SDIV_1US   = 8'h00;
  localparam logic [7:0] SDIV_100US = 8'h06;
  localparam logic [7:0] SDIV_200US = 8'h07;
  localparam logic [7:0] SDIV_MAX   = 8'h15;

  // ==========================================================
  // Error codes
  localparam logic [7:0] ERR_NONE     = 8'h00;
  localparam logic [7:0] ERR_POWERON  = 8'h01;
  localparam logic [7:0] ERR_BADCMD   = 8'h02;
  localparam logic [7:0] ERR_BADARG   = 8'h03;
  localparam logic [7:0] ERR_UNLOCKED = 8'h04;
  localparam int         NUM_ERR      = 8;
  localparam logic       RQS_RESET    = 1'b1;

  typedef struct packed {
    logic       locked;
    logic       ch1On;
    logic       ch2On;
    logic       bwLimit;
    logic [7:0] ch1Vdiv;
    logic [7:0] ch2Vdiv;
    logic [7:0] ch3Vdiv;
    logic [7:0] ch4Vdiv;
    logic [7:0] aSecDiv;
    logic [7:0] bSecDiv;
  } scope_type;

  localparam scope_type SCOPE_FACTORY = '{
    locked: 1'b0, ch1On: 1'b1, ch2On: 1'b1, bwLimit: 1'b0,
    ch1Vdiv: VDIV_100MV, ch2Vdiv: VDIV_100MV,
    ch3Vdiv: VDIV_100MV, ch4Vdiv: VDIV_100MV,
    aSecDiv: SDIV_100US, bSecDiv: SDIV_1US};

endpackage
`default_nettype wire

//--- fixture_cmd.sv
// The address map and register access over Wishbone are this design's own decisions.
`default_nettype none
module fixture_cmd
  import fixture_pkg::*;
#(
  // Arbitrary values, no real part behind them
  parameter logic [31:0] LOWER_VERSION = 32'h0000_0101,
  parameter logic [31:0] UPPER_VERSION = 32'h0000_0202
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        wbCycI,
  input  wire logic        wbStbI,
  input  wire logic        wbWeI,
  input  wire logic [7:0]  wbAdrI,
  input  wire logic [3:0]  wbSelI,
  input  wire logic [31:0] wbDatI,
  output logic      [31:0] wbDatO,
  output logic             wbAckO,
  input  wire logic [4:0]  addrSwitch,
  output logic             srq,
  output scope_type        scope,
  output logic             scopeUpdate
);

  // ==========================================================
  // Bus slave
  logic        ack_reg;
  logic [31:0] rdData_reg;
  logic        access;
  logic        wrCmd;
  logic        wrErr;
  logic        wrAck;
  logic        rdResp;

  // Registered ack: one wait state, no comb path back to the bus
  assign access = wbCycI && wbStbI && !ack_reg;
  assign wrCmd  = access && wbWeI && wbAdrI == CMD_OFFSET && wbSelI[0];
  assign wrErr  = access && wbWeI && wbAdrI == ERRIN_OFFSET && wbSelI[0];
  assign wrAck  = access && wbWeI && wbAdrI == SRQACK_OFFSET;
  assign rdResp = access && !wbWeI && wbAdrI == RESP_OFFSET;
  assign wbAckO = ack_reg;
  assign wbDatO = rdData_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access;
    end
  end

  // ==========================================================
  // Command capture, one at a time
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01
  } state_type;

  state_type   state_reg;
  logic [31:0] cmd_reg;
  logic        dropped_reg;
  logic        accept;
  opcode_type  op;
  logic [7:0]  arg;
  logic        isQuery;
  logic        exec;

  // Own address and EOI required; anything else is ignored
  assign accept = wrCmd && wbDatI[CMD_EOI_BIT] &&
                  wbDatI[CMD_ADDR_LSB +: 5] == addrSwitch;
  assign op      = opcode_type'(cmd_reg[CMD_OP_LSB +: 4]);
  assign arg     = cmd_reg[CMD_ARG_LSB +: 8];
  assign isQuery = cmd_reg[CMD_QUERY_BIT];
  assign exec    = state_reg == ST_EXEC;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= ST_IDLE;
      cmd_reg     <= 32'h0000_0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            cmd_reg   <= wbDatI;
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Decode
  logic queryOp;
  logic scopeOp;
  logic badForm;
  logic badArg;
  logic needLock;
  logic doRestore;

  assign queryOp = op == OP_IDENT || op == OP_NAME || op == OP_ERROR;
  assign scopeOp = op == OP_FACTORY || op == OP_CH2TOG ||
                   op == OP_CH1SCALE || op == OP_TIMEBASE ||
                   op == OP_BWTOG;

  always_comb begin
    badForm = 1'b0;
    badArg  = 1'b0;
    case (op)
      OP_RQS:      badArg = arg > ARG_QUERY;
      OP_CH1SCALE: badArg = arg > VDIV_MAX;
      OP_TIMEBASE: badArg = arg > SDIV_MAX;
      OP_IDENT, OP_NAME, OP_ERROR, OP_RESTORE, OP_LOCK, OP_UNLOCK,
      OP_FACTORY, OP_CH2TOG, OP_BWTOG: badForm = 1'b0;
      default:     badForm = 1'b1;
    endcase
    // A query missing its trailing mark is a malformed command
    if (queryOp && !isQuery) begin
      badForm = 1'b1;
    end
  end

  // Relayed commands only reach a locked scope
  assign needLock  = exec && scopeOp && !badArg && !scope.locked;
  assign doRestore = exec && !badForm && op == OP_RESTORE;

  // ==========================================================
  // Errors and service requests
  logic [NUM_ERR-1:0] pending_reg;
  logic [NUM_ERR-1:0] pending_next;
  logic               rqsEn_reg;
  logic               srq_reg;
  logic [7:0]         lastSrq_reg;
  logic               powerOn_reg;
  logic               errQuery;
  logic               raise;

  // Highest code wins; code zero means nothing pending
  function automatic logic [7:0] topCode(input logic [NUM_ERR-1:0] v);
    topCode = ERR_NONE;
    for (int i = 0; i < NUM_ERR; i++) begin
      if (v[i]) begin
        topCode = 8'(i);
      end
    end
  endfunction

  function automatic logic [NUM_ERR-1:0] codeBit(input logic [7:0] c);
    codeBit = '0;
    if (c != ERR_NONE && c < 8'(NUM_ERR)) begin
      codeBit[c[2:0]] = 1'b1;
    end
  endfunction

  assign errQuery = exec && !badForm && op == OP_ERROR;
  // Held back while disabled, released once enabled
  assign raise = rqsEn_reg && !srq_reg && |pending_reg;

  always_comb begin
    pending_next = pending_reg;
    if (errQuery && !rqsEn_reg) begin
      pending_next = pending_next & ~codeBit(topCode(pending_reg));
    end
    if (raise) begin
      pending_next = pending_next & ~codeBit(topCode(pending_reg));
    end
    if (doRestore) begin
      pending_next = '0;
    end
    // New events beat a same-cycle clear
    if (wrErr) begin
      pending_next = pending_next | codeBit(wbDatI[7:0]);
    end
    if (exec && badForm) begin
      pending_next = pending_next | codeBit(ERR_BADCMD);
    end
    if (exec && !badForm && badArg) begin
      pending_next = pending_next | codeBit(ERR_BADARG);
    end
    if (needLock) begin
      pending_next = pending_next | codeBit(ERR_UNLOCKED);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending_reg <= '0;
    end else begin
      pending_reg <= pending_next;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rqsEn_reg <= RQS_RESET;
    end else if (doRestore) begin
      rqsEn_reg <= RQS_RESET;
    end else if (exec && op == OP_RQS && !badArg &&
                 arg != ARG_QUERY) begin
      rqsEn_reg <= arg == ARG_ON;
    end
  end

  // Sticky; a drop in the restore cycle still shows
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dropped_reg <= 1'b0;
    end else if (exec && accept) begin
      dropped_reg <= 1'b1;
    end else if (doRestore) begin
      dropped_reg <= 1'b0;
    end
  end

  // Power-on request fires once, whatever the enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      powerOn_reg <= 1'b1;
      srq_reg     <= 1'b0;
      lastSrq_reg <= ERR_NONE;
    end else begin
      // Cleared first so a raise in the same cycle keeps its code
      if ((errQuery && rqsEn_reg) || doRestore) begin
        lastSrq_reg <= ERR_NONE;
      end
      if (powerOn_reg) begin
        powerOn_reg <= 1'b0;
        srq_reg     <= 1'b1;
        lastSrq_reg <= ERR_POWERON;
      end else if (raise) begin
        srq_reg     <= 1'b1;
        lastSrq_reg <= topCode(pending_reg);
      end else if (wrAck || doRestore) begin
        srq_reg <= 1'b0;
      end
    end
  end

  assign srq = srq_reg;

  // ==========================================================
  // Response
  logic [31:0] resp_reg;
  logic        respValid_reg;
  logic        respSet;
  logic [31:0] respNext;

  always_comb begin
    respSet  = 1'b0;
    respNext = resp_reg;
    if (doRestore) begin
      respNext = 32'h0000_0000;
    end
    if (exec && !badForm && !badArg) begin
      case (op)
        OP_IDENT: begin
          respSet  = 1'b1;
          respNext = LOWER_VERSION;
        end
        OP_NAME: begin
          respSet  = 1'b1;
          respNext = UPPER_VERSION;
        end
        OP_ERROR: begin
          respSet = 1'b1;
          if (rqsEn_reg) begin
            respNext = {24'h00_0000, lastSrq_reg};
          end else begin
            respNext = {24'h00_0000, topCode(pending_reg)};
          end
        end
        OP_RQS: begin
          if (arg == ARG_QUERY) begin
            respSet  = 1'b1;
            respNext = {31'h0000_0000, rqsEn_reg};
          end
        end
        default: respSet = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      resp_reg      <= 32'h0000_0000;
      respValid_reg <= 1'b0;
    end else begin
      resp_reg <= respNext;
      if (respSet) begin
        respValid_reg <= 1'b1;
      end else if (rdResp || doRestore) begin
        respValid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Scope relay
  scope_type scope_reg;
  logic      scopeUpd_reg;
  logic      scopeGo;

  // Unlocked scope ignores relayed settings; only the lock can land
  assign scopeGo = exec && !badForm && !badArg &&
                   (scope_reg.locked || op == OP_LOCK);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scope_reg    <= SCOPE_FACTORY;
      scopeUpd_reg <= 1'b0;
    end else begin
      scopeUpd_reg <= 1'b0;
      if (doRestore) begin
        scope_reg.locked <= 1'b0;
        scopeUpd_reg     <= 1'b1;
      end else if (exec && !badForm && op == OP_UNLOCK) begin
        scope_reg.locked <= 1'b0;
        scopeUpd_reg     <= 1'b1;
      end else if (scopeGo) begin
        scopeUpd_reg <= 1'b1;
        case (op)
          OP_LOCK: scope_reg.locked <= 1'b1;
          OP_FACTORY: begin
            scope_reg        <= SCOPE_FACTORY;
            scope_reg.locked <= 1'b1;
          end
          OP_CH2TOG:   scope_reg.ch2On   <= !scope_reg.ch2On;
          OP_CH1SCALE: scope_reg.ch1Vdiv <= arg;
          OP_TIMEBASE: scope_reg.aSecDiv <= arg;
          OP_BWTOG:    scope_reg.bwLimit <= !scope_reg.bwLimit;
          default:     scopeUpd_reg      <= 1'b0;
        endcase
      end
    end
  end

  assign scope       = scope_reg;
  assign scopeUpdate = scopeUpd_reg;

  // ==========================================================
  // Read mux
  logic [31:0] rdMux;

  always_comb begin
    case (wbAdrI)
      STATUS_OFFSET: rdMux = {26'h000_0000, dropped_reg,
                              scope_reg.locked, respValid_reg,
                              rqsEn_reg, srq_reg, exec};
      RESP_OFFSET:   rdMux = resp_reg;
      ERRIN_OFFSET:  rdMux = {24'h00_0000, pending_reg};
      SCOPE_OFFSET:  rdMux = {scope_reg.bSecDiv, scope_reg.aSecDiv,
                              scope_reg.ch1Vdiv, 4'h0,
                              scope_reg.locked, scope_reg.ch1On,
                              scope_reg.ch2On, scope_reg.bwLimit};
      default:       rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData_reg <= 32'h0000_0000;
    end else if (access && !wbWeI) begin
      rdData_reg <= rdMux;
    end
  end

endmodule
`default_nettype wire

//--- fixture_cmd_assertions.sv
`default_nettype none
module fixture_cmd_checker
  import fixture_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        wbCycI,
  input wire logic        wbStbI,
  input wire logic        wbWeI,
  input wire logic [7:0]  wbAdrI,
  input wire logic [31:0] wbDatI,
  input wire logic        wbAckO,
  input wire logic [4:0]  addrSwitch,
  input wire logic        srq,
  input wire scope_type   scope
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Command capture
  logic       wrTake;
  logic       hit;
  logic [3:0] op;
  scope_type  seen_reg;
  assign wrTake = wbCycI && wbStbI && wbWeI && !wbAckO
                  && wbAdrI == CMD_OFFSET;
  assign hit = wrTake && wbDatI[24] && wbDatI[4:0] == addrSwitch;
  assign op = wbDatI[11:8];
  // Snapshot lets toggles be judged against the prior state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seen_reg <= SCOPE_FACTORY;
    end else if (wrTake) begin
      seen_reg <= scope;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========
  // Checks
  chk_lock_sets:
    assert property (hit && op == OP_LOCK |-> ##[1:5] scope.locked)
    else $error("lock not applied");
  chk_restore_unlock:
    assert property (hit && op == OP_RESTORE |-> ##[1:5] !scope.locked)
    else $error("restore left scope locked");
  chk_restore_quiet:
    assert property (hit && op == OP_RESTORE |-> ##5 !srq [*3])
    else $error("restore raised a request");
  chk_factory_vals:
    assert property (hit && op == OP_FACTORY && scope.locked |->
      ##[1:5] scope.ch1On && scope.ch2On && scope.ch1Vdiv == VDIV_100MV
      && scope.aSecDiv == SDIV_100US && scope.bSecDiv == SDIV_1US)
    else $error("factory values wrong");
  chk_ch2_flip:
    assert property (hit && op == OP_CH2TOG && scope.locked |->
      ##[1:5] scope.ch2On != seen_reg.ch2On)
    else $error("channel two not toggled");
  chk_ch1_scale:
    assert property (hit && op == OP_CH1SCALE && scope.locked
      && wbDatI[23:16] == VDIV_10MV |-> ##[1:5] scope.ch1Vdiv == VDIV_10MV)
    else $error("channel one scale wrong");
  chk_bw_flip:
    assert property (hit && op == OP_BWTOG && scope.locked |->
      ##[1:5] scope.bwLimit != seen_reg.bwLimit)
    else $error("bandwidth limit not toggled");
  chk_foreign_addr:
    assert property (wrTake && wbDatI[4:0] != addrSwitch |=>
      (scope == seen_reg) [*5])
    else $error("foreign address changed scope");
  cover property (hit && op == OP_FACTORY);
  cover property (hit && op == OP_RESTORE);
  cover property (wrTake && wbDatI[4:0] != addrSwitch);
endmodule
bind fixture_cmd fixture_cmd_checker i_chk (
  .clk, .rstn, .wbCycI, .wbStbI, .wbWeI, .wbAdrI, .wbDatI,
  .wbAckO, .addrSwitch, .srq, .scope
);
`default_nettype wire

//--- gpib_controller_model.sv
`default_nettype none
module gpib_controller_model
  import fixture_pkg::*;
(
  input  wire logic        clk,
  output logic             wbCycI,
  output logic             wbStbI,
  output logic             wbWeI,
  output logic [7:0]       wbAdrI,
  output logic [3:0]       wbSelI,
  output logic [31:0]      wbDatI,
  input  wire logic [31:0] wbDatO,
  input  wire logic        wbAckO
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wbCycI = 1'b0;
    wbStbI = 1'b0;
    wbWeI = 1'b0;
    wbAdrI = 8'h00;
    wbSelI = 4'hF;
    wbDatI = 32'h0;
  end
  // ==========
  // One classic cycle, held until ack is sampled
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat, output logic [31:0] q);
    @(posedge clk);
    wbCycI <= 1'b1;
    wbStbI <= 1'b1;
    wbWeI <= we;
    wbAdrI <= adr;
    wbDatI <= dat;
    // Only the bench watchdog ends a wait that never sees ack
    do begin
      @(posedge clk);
    end while (wbAckO !== 1'b1);
    q = wbDatO;
    wbCycI <= 1'b0;
    wbStbI <= 1'b0;
    // Released data must not look valid
    wbDatI <= ~dat;
  endtask
  // Every message ends with EOI; qm marks the query form
  task automatic send(input logic [3:0] op, input logic [7:0] arg,
                      input logic qm, input logic [4:0] adr);
    logic [31:0] q;
    xfer(1'b1, CMD_OFFSET, {6'h0, qm, 1'b1, arg, 4'h0, op, 3'h0, adr},
         q);
  endtask
endmodule
`default_nettype wire

//--- fixture_cmd_tb.sv
`default_nettype none
module fixture_cmd_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fixture_pkg::*;
  // Arbitrary version words
  localparam logic [31:0] LOW_VER = 32'h0000_3C41;
  localparam logic [31:0] UP_VER  = 32'h0000_5E72;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [4:0]  addrSwitch = 5'h17;
  logic        wbCycI;
  logic        wbStbI;
  logic        wbWeI;
  logic [7:0]  wbAdrI;
  logic [3:0]  wbSelI;
  logic [31:0] wbDatI;
  logic [31:0] wbDatO;
  logic        wbAckO;
  logic        srq;
  scope_type   scope;
  logic        scopeUpdate;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          updCount = 0;
  always #50 clk = ~clk;
  // Relay pulses counted so each scope change is seen reported once
  always @(posedge clk) begin
    if (scopeUpdate === 1'b1) begin
      updCount++;
    end
  end
  fixture_cmd #(.LOWER_VERSION(LOW_VER), .UPPER_VERSION(UP_VER))
  i_fixture_cmd (.clk, .rstn, .wbCycI, .wbStbI, .wbWeI, .wbAdrI,
    .wbSelI, .wbDatI, .wbDatO, .wbAckO, .addrSwitch, .srq, .scope,
    .scopeUpdate);
  gpib_controller_model i_gpib_controller_model (.clk, .wbCycI,
    .wbStbI, .wbWeI, .wbAdrI, .wbSelI, .wbDatI, .wbDatO, .wbAckO);
  // ==========
  // Helpers
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %0h vs %0h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] adr, output logic [31:0] q);
    i_gpib_controller_model.xfer(1'b0, adr, 32'h0, q);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] q;
    i_gpib_controller_model.xfer(1'b1, adr, d, q);
  endtask
  task automatic poll(input int b, input logic v);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      rd(STATUS_OFFSET, q);
      n++;
    end while (q[b] !== v && n < 40);
    check(q[b], v);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [7:0] arg);
    i_gpib_controller_model.send(op, arg, 1'b0, addrSwitch);
    poll(0, 1'b0);
  endtask
  task automatic ask(input logic [3:0] op, input logic [7:0] arg,
                     input logic [31:0] exp);
    logic [31:0] q;
    i_gpib_controller_model.send(op, arg, 1'b1, addrSwitch);
    poll(3, 1'b1);
    rd(RESP_OFFSET, q);
    check(q, exp);
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========
  // Sequence
  initial begin
    scope_type   sf;
    logic [31:0] q;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    check(srq, 1'b1);
    ask(OP_ERROR, ARG_OFF, {24'h0, ERR_POWERON});
    ask(OP_ERROR, ARG_OFF, 32'h0);
    ask(OP_IDENT, ARG_OFF, LOW_VER);
    ask(OP_NAME, ARG_OFF, UP_VER);
    cmd(OP_IDENT, ARG_OFF);
    i_gpib_controller_model.send(OP_NAME, ARG_OFF, 1'b1, 5'h16);
    poll(0, 1'b0);
    rd(STATUS_OFFSET, q);
    check(q[3], 1'b0);
    wr(SRQACK_OFFSET, 32'h0);
    ask(OP_ERROR, ARG_OFF, {24'h0, ERR_BADCMD});
    wr(SRQACK_OFFSET, 32'h0);
    cmd(OP_RQS, ARG_OFF);
    wr(ERRIN_OFFSET, 32'h3);
    wr(ERRIN_OFFSET, 32'h5);
    repeat (4) @(posedge clk);
    check(srq, 1'b0);
    ask(OP_RQS, ARG_QUERY, 32'h0);
    ask(OP_ERROR, ARG_OFF, 32'h5);
    cmd(OP_RQS, ARG_ON);
    check(srq, 1'b1);
    ask(OP_ERROR, ARG_OFF, 32'h3);
    ask(OP_RQS, ARG_QUERY, 32'h1);
    cmd(OP_LOCK, ARG_OFF);
    check(scope.locked, 1'b1);
    cmd(OP_CH2TOG, ARG_OFF);
    check({scope.ch1On, scope.ch2On}, 2'b10);
    cmd(OP_CH1SCALE, VDIV_10MV);
    check(scope.ch1Vdiv, VDIV_10MV);
    cmd(OP_TIMEBASE, SDIV_200US);
    check(scope.aSecDiv, SDIV_200US);
    cmd(OP_BWTOG, ARG_OFF);
    check(scope.bwLimit, 1'b1);
    cmd(OP_FACTORY, ARG_OFF);
    sf = SCOPE_FACTORY;
    sf.locked = 1'b1;
    check(scope, sf);
    cmd(OP_CH2TOG, ARG_OFF);
    wr(ERRIN_OFFSET, 32'h6);
    cmd(OP_RESTORE, ARG_OFF);
    sf.locked = 1'b0;
    sf.ch2On = 1'b0;
    check(scope, sf);
    check(srq, 1'b0);
    rd(STATUS_OFFSET, q);
    check(q[2], 1'b1);
    ask(OP_ERROR, ARG_OFF, 32'h0);
    rd(SCOPE_OFFSET, q);
    check(q, {SDIV_1US, SDIV_100US, VDIV_100MV, 8'h04});
    cmd(OP_BWTOG, ARG_OFF);
    check(scope, sf);
    ask(OP_ERROR, ARG_OFF, {24'h0, ERR_UNLOCKED});
    wr(SRQACK_OFFSET, 32'h0);
    cmd(OP_RQS, 8'h03);
    ask(OP_ERROR, ARG_OFF, {24'h0, ERR_BADARG});
    cmd(OP_LOCK, ARG_OFF);
    cmd(OP_UNLOCK, ARG_OFF);
    check(scope.locked, 1'b0);
    check(64'(updCount), 64'hA);
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
